// File: lpm_consts.svh
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
// Bus address and register offsets
`define LPM_I2C_ADDR   7'h44
`define LPM_REG_CMD1   8'h00
`define LPM_REG_CMD2   8'h01
`define LPM_REG_DATA_L 8'h02
`define LPM_REG_DATA_H 8'h03
`define LPM_REG_TLO_L  8'h04
`define LPM_REG_TLO_H  8'h05
`define LPM_REG_THI_L  8'h06
`define LPM_REG_THI_H  8'h07
// Reset values
`define LPM_CMD2_RST   8'h00
`define LPM_DATA_RST   16'h0000
`define LPM_TLO_RST    16'h0000
`define LPM_THI_RST    16'hFFFF
// Operating mode codes, continuous bit index and proximity channel code
`define LPM_MODE_OFF   3'h0
`define LPM_MODE_RSVD  3'h4
`define LPM_MODE_CONT  2
`define LPM_CHAN_PROX  2'h3
// Second command byte fields
`define LPM_SCHEME     7
`define LPM_FREQ       6
// Conversion lengths in oscillator ticks
`define LPM_TICKS_16   17'h10000
`define LPM_TICKS_12   17'h01000
`define LPM_TICKS_8    17'h00100
`define LPM_TICKS_4    17'h00010
// Persistence counts
`define LPM_PERS_1     5'h01
`define LPM_PERS_4     5'h04
`define LPM_PERS_8     5'h08
`define LPM_PERS_16    5'h10
// Byte framing
`define LPM_BITS_BYTE  4'h8
`define LPM_BIT_LAST   4'h7
// LED modulation timing
`define LPM_CLK_MHZ    10
`define LPM_MOD_HALF_NS 1389
`define LPM_MOD_HALF_CYC ((`LPM_MOD_HALF_NS * `LPM_CLK_MHZ) / 1000)
`endif

// File: lpm_pkg.sv
package lpm_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_RX, I2C_ACKOUT, I2C_TX, I2C_ACKIN
  } lpm_i2c_state_t;
  typedef enum logic {SEQ_OFF, SEQ_CONV} lpm_seq_state_t;
endpackage

// File: lpm_sync.sv
`timescale 1ns/1ns
`default_nettype none
module lpm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  // Idle bus level is high, so reset to ones
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg <= '1;
      dout     <= '1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: lpm_sequencer.sv
`include "lpm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module lpm_sequencer
  import lpm_pkg::*;
#(
  parameter logic [16:0] CONV_TICKS_16 = `LPM_TICKS_16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Serial bus pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Interrupt pin, open drain
  output logic             intOut,
  output logic             intOe,
  // Analog front end
  input  wire logic [15:0] adcSample,
  output logic [1:0]       channelSel,
  output logic [1:0]       rangeSel,
  output logic [1:0]       ledAmp,
  output logic             irLedDriveOut,
  output logic             convBusy,
  output logic             intFlag
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0]     pinSync;
  logic           sclPrev_reg, sdaPrev_reg;
  lpm_i2c_state_t i2cState_reg;
  logic [7:0]     shift_reg, ptr_reg;
  logic [3:0]     bitCnt_reg;
  logic           isAddr_reg, gotPtr_reg, rw_reg, ackRx_reg, sdaOe_reg;
  lpm_seq_state_t seq_reg;
  logic [2:0]     mode_reg;
  logic [1:0]     persist_reg;
  logic           flag_reg, irLed_reg, modPhase_reg;
  logic [7:0]     cmd2_reg;
  logic [15:0]    data_reg, tlo_reg, thi_reg;
  logic [16:0]    convCnt_reg;
  logic [4:0]     persistCnt_reg;
  logic [7:0]     modCnt_reg;

  lpm_sync #(.WIDTH(2)) uPinSync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      ({sclIn, sdaIn}),
    .dout     (pinSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus condition decode
  wire logic sclS      = pinSync[1];
  wire logic sdaS      = pinSync[0];
  wire logic sclRise   = sclS & ~sclPrev_reg;
  wire logic sclFall   = ~sclS & sclPrev_reg;
  wire logic startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  wire logic stopCond  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  wire logic byteIn    = (i2cState_reg == I2C_RX) & sclFall &
                         (bitCnt_reg == `LPM_BITS_BYTE);
  wire logic addrHit   = shift_reg[7:1] == `LPM_I2C_ADDR;
  wire logic wrStb     = byteIn & ~isAddr_reg & gotPtr_reg;
  wire logic rdDone    = (i2cState_reg == I2C_ACKIN) & sclRise;
  wire logic reg0Done  = (wrStb | rdDone) & (ptr_reg == `LPM_REG_CMD1);
  wire logic modeWr    = wrStb & (ptr_reg == `LPM_REG_CMD1);
  wire logic [2:0] newMode = shift_reg[7:5];

  // Unmapped offsets, including the test register, read as zero
  wire logic [7:0] rdByte =
    (ptr_reg == `LPM_REG_CMD1)   ? {mode_reg, 2'h0, flag_reg, persist_reg} :
    (ptr_reg == `LPM_REG_CMD2)   ? cmd2_reg :
    (ptr_reg == `LPM_REG_DATA_L) ? data_reg[7:0] :
    (ptr_reg == `LPM_REG_DATA_H) ? data_reg[15:8] :
    (ptr_reg == `LPM_REG_TLO_L)  ? tlo_reg[7:0] :
    (ptr_reg == `LPM_REG_TLO_H)  ? tlo_reg[15:8] :
    (ptr_reg == `LPM_REG_THI_L)  ? thi_reg[7:0] :
    (ptr_reg == `LPM_REG_THI_H)  ? thi_reg[15:8] : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave; start and stop abort any byte in progress
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclPrev_reg  <= 1'b1;
      sdaPrev_reg  <= 1'b1;
      i2cState_reg <= I2C_IDLE;
      shift_reg    <= '0;
      ptr_reg      <= '0;
      bitCnt_reg   <= '0;
      isAddr_reg   <= 1'b0;
      gotPtr_reg   <= 1'b0;
      rw_reg       <= 1'b0;
      ackRx_reg    <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
      if (startCond) begin
        i2cState_reg <= I2C_RX;
        bitCnt_reg   <= '0;
        isAddr_reg   <= 1'b1;
        gotPtr_reg   <= 1'b0;
        sdaOe_reg    <= 1'b0;
      end else if (stopCond) begin
        i2cState_reg <= I2C_IDLE;
        sdaOe_reg    <= 1'b0;
      end else begin
        case (i2cState_reg)
          I2C_RX: begin
            if (sclRise && bitCnt_reg != `LPM_BITS_BYTE) begin
              shift_reg  <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (byteIn && isAddr_reg) begin
              if (addrHit) begin
                rw_reg       <= shift_reg[0];
                sdaOe_reg    <= 1'b1;
                i2cState_reg <= I2C_ACKOUT;
              end else begin
                i2cState_reg <= I2C_IDLE;
              end
            end else if (byteIn) begin
              sdaOe_reg    <= 1'b1;
              i2cState_reg <= I2C_ACKOUT;
              gotPtr_reg   <= 1'b1;
              if (!gotPtr_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          I2C_ACKOUT: begin
            if (sclFall) begin
              isAddr_reg <= 1'b0;
              bitCnt_reg <= '0;
              if (rw_reg) begin
                shift_reg    <= rdByte;
                sdaOe_reg    <= ~rdByte[7];
                i2cState_reg <= I2C_TX;
              end else begin
                sdaOe_reg    <= 1'b0;
                i2cState_reg <= I2C_RX;
              end
            end
          end
          I2C_TX: begin
            if (sclFall && bitCnt_reg == `LPM_BIT_LAST) begin
              sdaOe_reg    <= 1'b0;
              i2cState_reg <= I2C_ACKIN;
            end else if (sclFall) begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sdaOe_reg  <= ~shift_reg[6];
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
          I2C_ACKIN: begin
            if (sclRise) begin
              ackRx_reg <= ~sdaS;
              ptr_reg   <= ptr_reg + 8'h01;
            end else if (sclFall && ackRx_reg) begin
              shift_reg    <= rdByte;
              sdaOe_reg    <= ~rdByte[7];
              bitCnt_reg   <= '0;
              i2cState_reg <= I2C_TX;
            end else if (sclFall) begin
              i2cState_reg <= I2C_IDLE;
            end
          end
          default: begin
            sdaOe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result formatting and window compare
  wire logic [1:0] res = cmd2_reg[3:2];
  wire logic [16:0] convLen = (res == 2'h0) ? CONV_TICKS_16 :
                              (res == 2'h1) ? `LPM_TICKS_12 :
                              (res == 2'h2) ? `LPM_TICKS_8 : `LPM_TICKS_4;
  wire logic [15:0] resMask = (res == 2'h0) ? 16'hFFFF :
                              (res == 2'h1) ? 16'h0FFF :
                              (res == 2'h2) ? 16'h00FF : 16'h000F;
  wire logic [15:0] signPos = resMask ^ {1'b0, resMask[15:1]};
  wire logic [15:0] rawMask = adcSample & resMask;
  wire logic isSigned = (mode_reg[1:0] == `LPM_CHAN_PROX) &
                        cmd2_reg[`LPM_SCHEME];
  wire logic signBit  = |(rawMask & signPos);
  wire logic [15:0] resultFmt = (isSigned & signBit) ? (rawMask | ~resMask)
                                                     : rawMask;
  wire logic aboveHi = isSigned ? ($signed(resultFmt) > $signed(thi_reg))
                                : (resultFmt > thi_reg);
  wire logic belowLo = isSigned ? ($signed(resultFmt) < $signed(tlo_reg))
                                : (resultFmt < tlo_reg);
  wire logic outWin  = aboveHi | belowLo;
  wire logic [4:0] persistNeed = (persist_reg == 2'h0) ? `LPM_PERS_1 :
                                 (persist_reg == 2'h1) ? `LPM_PERS_4 :
                                 (persist_reg == 2'h2) ? `LPM_PERS_8
                                                       : `LPM_PERS_16;
  wire logic [4:0] persistInc = (persistCnt_reg == `LPM_PERS_16) ?
                                persistCnt_reg : persistCnt_reg + 5'h01;
  // Shorter resolution written mid-run must not skip the end
  wire logic convEnd = (seq_reg == SEQ_CONV) &
                       (convCnt_reg >= convLen - 17'h00001);
  wire logic setEvt  = convEnd & ~modeWr & outWin &
                       (persistInc >= persistNeed);
  // A new event beats the clear in the same cycle
  wire logic flagNext = setEvt | (flag_reg & ~reg0Done);
  wire logic ledOn = (seq_reg == SEQ_CONV) &
                     (mode_reg[1:0] == `LPM_CHAN_PROX) &
                     (~cmd2_reg[`LPM_FREQ] | modPhase_reg);
  wire logic modWrap = modCnt_reg == 8'(`LPM_MOD_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Configuration and thresholds
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      persist_reg <= '0;
      cmd2_reg    <= `LPM_CMD2_RST;
      tlo_reg     <= `LPM_TLO_RST;
      thi_reg     <= `LPM_THI_RST;
    end else if (wrStb) begin
      case (ptr_reg)
        `LPM_REG_CMD1:  persist_reg   <= shift_reg[1:0];
        `LPM_REG_CMD2:  cmd2_reg      <= shift_reg;
        `LPM_REG_TLO_L: tlo_reg[7:0]  <= shift_reg;
        `LPM_REG_TLO_H: tlo_reg[15:8] <= shift_reg;
        `LPM_REG_THI_L: thi_reg[7:0]  <= shift_reg;
        `LPM_REG_THI_H: thi_reg[15:8] <= shift_reg;
        default: ;
      endcase
    end
  end

  // Conversion sequencer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seq_reg        <= SEQ_OFF;
      mode_reg       <= `LPM_MODE_OFF;
      data_reg       <= `LPM_DATA_RST;
      convCnt_reg    <= '0;
      persistCnt_reg <= '0;
      flag_reg       <= 1'b0;
    end else begin
      flag_reg <= flagNext;
      if (modeWr) begin
        mode_reg       <= newMode;
        convCnt_reg    <= '0;
        persistCnt_reg <= '0;
        seq_reg <= (newMode == `LPM_MODE_OFF || newMode == `LPM_MODE_RSVD)
                   ? SEQ_OFF : SEQ_CONV;
      end else if (convEnd) begin
        convCnt_reg    <= '0;
        data_reg       <= resultFmt;
        persistCnt_reg <= outWin ? persistInc : 5'h00;
        if (!mode_reg[`LPM_MODE_CONT]) begin
          seq_reg  <= SEQ_OFF;
          mode_reg <= `LPM_MODE_OFF;
        end
      end else if (seq_reg == SEQ_CONV) begin
        convCnt_reg <= convCnt_reg + 17'h00001;
      end
    end
  end

  // LED modulation divider and registered drive
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      modCnt_reg   <= '0;
      modPhase_reg <= 1'b0;
      irLed_reg    <= 1'b0;
    end else begin
      modCnt_reg   <= modWrap ? 8'h00 : modCnt_reg + 8'h01;
      modPhase_reg <= modPhase_reg ^ modWrap;
      irLed_reg    <= ledOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain pins only ever pull low
  assign sdaOut        = 1'b0;
  assign sdaOe         = sdaOe_reg;
  assign intOut        = 1'b0;
  assign intOe         = flag_reg;
  assign intFlag       = flag_reg;
  assign channelSel    = mode_reg[1:0];
  assign rangeSel      = cmd2_reg[1:0];
  assign ledAmp        = cmd2_reg[5:4];
  assign irLedDriveOut = irLed_reg;
  assign convBusy      = seq_reg == SEQ_CONV;

  ////////////////////////////////////////////////////////////////////////
  a_single_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    convEnd && !mode_reg[2] && !modeWr |=> seq_reg == SEQ_OFF &&
      mode_reg == `LPM_MODE_OFF ##1
      (seq_reg == SEQ_OFF || $past(modeWr)))
    else $error("single shot did not power down");
  a_cont_restart: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    convEnd && mode_reg[2] && !modeWr |=> seq_reg == SEQ_CONV &&
      convCnt_reg == 17'h00000 && data_reg == $past(resultFmt))
    else $error("continuous conversion did not restart with new data");
  a_off_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    modeWr && newMode == `LPM_MODE_OFF |=> !convBusy ##1 !convBusy)
    else $error("power down write ignored");
  a_conv_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    convCnt_reg < convLen || $past(wrStb))
    else $error("conversion counter overran its length");
  a_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    setEvt |=> flag_reg && intOe)
    else $error("interrupt not raised on window exit");
  a_flag_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    flag_reg && !reg0Done |=> flag_reg)
    else $error("interrupt dropped without clear");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg0Done && !setEvt |=> !flag_reg && !intOe)
    else $error("interrupt not cleared by command access");
  a_persist_reset: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    convEnd && !modeWr && !outWin |=> persistCnt_reg == 5'h00 && !setEvt)
    else $error("persistence count kept after in-window result");
  a_led_only_prox: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    irLedDriveOut |-> $past(convBusy) && $past(mode_reg[1:0]) == 2'h3)
    else $error("LED driven outside proximity conversion");
  a_addr_miss: assert property (@(posedge core_clk) disable iff (!reset_n)
    byteIn && isAddr_reg && !addrHit && !startCond && !stopCond
    |=> i2cState_reg == I2C_IDLE && !sdaOe)
    else $error("slave answered a foreign address");
endmodule
`default_nettype wire

// File: lpm_i2c_host.sv
`timescale 1ns/1ns
`default_nettype none
module lpm_i2c_host (
  // Bus pins; SDA open drain only, SCL driven high and low
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  // Long low phase: slave data lands 2-3 clocks after the fall
  localparam int T_LOW  = 500;
  localparam int T_HIGH = 300;
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  // Start or repeated start; clock stands high between frames
  task automatic start();
    #100 sdaLow = 1'b0;
    #100 scl = 1'b1;
    #(T_HIGH) sdaLow = 1'b1;
    #(T_HIGH) scl = 1'b0;
  endtask
  task automatic bitx(input logic b, output logic s);
    #100 sdaLow = ~b;
    #(T_LOW-100) scl = 1'b1;
    #150 s = sda;
    #(T_HIGH-150) scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      b[i] = s;
    end
    bitx(nack, s);
  endtask
  task automatic stop();
    #100 sdaLow = 1'b1;
    #(T_LOW-100) scl = 1'b1;
    #(T_HIGH) sdaLow = 1'b0;
    #(T_HIGH);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lpm_pkg::*;
  logic        core_clk;
  logic        reset_n;
  logic        scl;
  logic        mdlLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        intOut;
  logic        intOe;
  logic [15:0] adcSample;
  logic [1:0]  channelSel;
  logic [1:0]  rangeSel;
  logic [1:0]  ledAmp;
  logic        irLedDriveOut;
  logic        convBusy;
  logic        intFlag;
  logic [15:0] d;
  int          failures;
  int          tests_run;
  int          cycles;
  int          cnt;
  wire  logic  sdaWire;
  // Pull-up wins unless someone pulls low
  assign sdaWire = ~((sdaOe & ~sdaOut) | mdlLow);
  lpm_i2c_host mdl (.scl(scl), .sdaLow(mdlLow), .sda(sdaWire));
  // Short conversions keep the run small: 32 cycles at res 0
  lpm_sequencer #(.CONV_TICKS_16(17'h00020)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .intOut(intOut), .intOe(intOe), .adcSample(adcSample),
    .channelSel(channelSel), .rangeSel(rangeSel), .ledAmp(ledAmp),
    .irLedDriveOut(irLedDriveOut), .convBusy(convBusy),
    .intFlag(intFlag));
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic setAdc(input logic [15:0] v);
    @(posedge core_clk);
    #10 adcSample = v;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  // Bytes go LSB first to successive offsets
  task automatic wr(input logic [7:0] p, input logic [15:0] v,
                    input int n);
    logic a;
    logic all;
    mdl.start();
    mdl.wbyte(8'h88, all);
    mdl.wbyte(p, a);
    all = all & a;
    for (int i = 0; i < n; i++) begin
      mdl.wbyte(v[8*i +: 8], a);
      all = all & a;
    end
    mdl.stop();
    chk({15'h0000, all}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [15:0] v);
    logic a;
    logic [7:0] b;
    v = 16'h0000;
    mdl.start();
    mdl.wbyte(8'h88, a);
    mdl.wbyte(p, a);
    mdl.start();
    mdl.wbyte(8'h89, a);
    for (int i = 0; i < n; i++) begin
      mdl.rbyte(b, i == n - 1);
      v[8*i +: 8] = b;
    end
    mdl.stop();
  endtask
  task automatic rdChk(input logic [7:0] p, input int n,
                       input logic [15:0] e);
    logic [15:0] v;
    rd(p, n, v);
    chk(v, e);
  endtask
  task automatic waitIdle();
    for (int k = 0; k < 200 && convBusy !== 1'b0; k++) clk(1);
    chk({15'h0000, convBusy}, 16'h0000);
  endtask
  task automatic waitFlag(input int lim);
    for (int k = 0; k < lim && intFlag !== 1'b1; k++) clk(1);
    chk({15'h0000, intFlag}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic a;
    reset_n = 1'b0;
    adcSample = 16'h0000;
    clk(5);
    reset_n = 1'b1;
    clk(3);
    chk({14'h0000, channelSel}, 16'h0000);
    rdChk(8'h00, 2, 16'h0000);
    rdChk(8'h02, 2, 16'h0000);
    rdChk(8'h04, 2, 16'h0000);
    rdChk(8'h06, 2, 16'hFFFF);
    rdChk(8'h08, 1, 16'h0000);
    // Foreign address gets no acknowledge
    mdl.start();
    mdl.wbyte(8'h8A, a);
    mdl.stop();
    chk({15'h0000, a}, 16'h0000);
    // Single shot, then data retained
    setAdc(16'h1234);
    wr(8'h00, 16'h0020, 1);
    chk({15'h0000, convBusy}, 16'h0001);
    waitIdle();
    rdChk(8'h00, 1, 16'h0000);
    rdChk(8'h02, 2, 16'h1234);
    setAdc(16'h5555);
    clk(100);
    rdChk(8'h02, 2, 16'h1234);
    // Command pair in one transfer
    wr(8'h00, 16'h2300, 2);
    chk({14'h0000, rangeSel}, 16'h0003);
    chk({14'h0000, ledAmp}, 16'h0002);
    // Powered down before thresholds change
    wr(8'h04, 16'h0100, 2);
    wr(8'h06, 16'h2000, 2);
    rdChk(8'h04, 2, 16'h0100);
    rdChk(8'h06, 2, 16'h2000);
    // Continuous IR, window crossing on the high side
    setAdc(16'h1000);
    wr(8'h00, 16'h00C0, 1);
    chk({14'h0000, channelSel}, 16'h0002);
    clk(40);
    chk({15'h0000, intFlag}, 16'h0000);
    setAdc(16'h2222);
    waitFlag(80);
    chk({15'h0000, intOe}, 16'h0001);
    rdChk(8'h02, 2, 16'h2222);
    setAdc(16'h1000);
    clk(100);
    chk({15'h0000, intFlag}, 16'h0001);
    rdChk(8'h00, 1, 16'h00C4);
    chk({14'h0000, intFlag, intOe}, 16'h0000);
    // Persist of 4 below the low threshold
    wr(8'h00, 16'h00C1, 1);
    setAdc(16'h0050);
    clk(90);
    chk({15'h0000, intFlag}, 16'h0000);
    waitFlag(120);
    // Modulated LED during proximity conversions
    wr(8'h00, 16'h0000, 1);
    wr(8'h01, 16'h0040, 1);
    wr(8'h00, 16'h00E0, 1);
    chk({14'h0000, channelSel}, 16'h0003);
    cnt = 0;
    for (int k = 0; k < 100; k++) begin
      a = irLedDriveOut;
      clk(1);
      if (irLedDriveOut !== a) cnt++;
    end
    chk({15'h0000, cnt >= 6}, 16'h0001);
    wr(8'h00, 16'h0000, 1);
    clk(5);
    chk({14'h0000, convBusy, irLedDriveOut}, 16'h0000);
    rd(8'h02, 2, d);
    setAdc(16'h0777);
    clk(100);
    rdChk(8'h02, 2, d);
    // Every mode code in turn, no reset between
    for (int m = 1; m < 8; m++) begin
      wr(8'h00, {8'h00, m[2:0], 5'h00}, 1);
      chk({14'h0000, channelSel}, (m == 4) ? 16'h0 : m[1:0]);
      chk({15'h0000, convBusy}, {15'h0000, m != 4});
    end
    wr(8'h00, 16'h0000, 1);
    waitIdle();
    chk({14'h0000, sdaOut, intOut}, 16'h0000);
    // Four-bit results: unsigned mask, then signed proximity
    wr(8'h04, 16'h0000, 2);
    wr(8'h01, 16'h000C, 1);
    setAdc(16'hFFFF);
    wr(8'h00, 16'h0020, 1);
    waitIdle();
    rdChk(8'h02, 2, 16'h000F);
    chk({15'h0000, intFlag}, 16'h0000);
    wr(8'h01, 16'h008C, 1);
    setAdc(16'h000A);
    wr(8'h00, 16'h0060, 1);
    waitIdle();
    rdChk(8'h02, 2, 16'hFFFA);
    chk({15'h0000, intFlag}, 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
